// *** bypass_defs.svh ***
// Offsets, field positions, reset values and timing counts of the bypass sequencer.
`ifndef BYPASS_DEFS_SVH
`define BYPASS_DEFS_SVH
`define ADDR_CONFIG      12'h000
`define ADDR_DEADTIME    12'h004
`define ADDR_RETURN      12'h008
`define ADDR_FAULTDLY    12'h00C
`define ADDR_SPEED_THR   12'h010
`define ADDR_TRIG_SRC    12'h014
`define ADDR_SYNC_CFG    12'h018
`define ADDR_SYNC_THR    12'h01C
`define ADDR_CTRL_STATUS 12'h020
`define ADDR_SYNC_DIFF   12'h024
`define ADDR_SYNC_STATUS 12'h028
`define BIT_CONV_CONT    0
`define BIT_LINE_CONT    1
`define BIT_SYNC_REQ     2
`define BIT_PULSE_INH    3
`define BIT_BYPASSED     4
`define BIT_SYNC_MATCH   2
`define TRIG_CTRL        0
`define TRIG_SPEED       1
`define TRIG_FAULT       2
`define MODE_SYNC_OVL    2'h1
`define MODE_SYNC_NOOVL  2'h2
`define MODE_NOSYNC      2'h3
`define SYNC_INTERNAL    2'h1
`define SYNC_EXTERNAL    2'h2
`define RST_DEADTIME     32'h0000_01F4
`define RST_RETURN       32'h0000_01F4
`define RST_FAULTDLY     32'h0000_01F4
`endif

// *** bypass_pkg.sv ***
// Types shared by the bypass sequencer files.
package bypass_pkg;
  typedef enum logic [3:0] {
    ST_CONV,
    ST_FAULT_DLY,
    ST_OPEN_CONV,
    ST_DEAD_IN,
    ST_SYNC_WAIT,
    ST_LINE_WAIT,
    ST_BYPASSED,
    ST_RET_DLY,
    ST_OPEN_LINE,
    ST_DEAD_OUT,
    ST_CONV_WAIT
  } seq_state_t;
  typedef struct packed {
    logic        ctrl_request;
    logic        fault;
    logic [15:0] speed_setpoint;
  } triggers_t;
  typedef struct packed {
    logic signed [15:0] u12;
    logic signed [15:0] u23;
    logic signed [15:0] model_u12;
    logic signed [15:0] model_u23;
    logic signed [15:0] line_u12;
    logic signed [15:0] line_u23;
    logic signed [15:0] motor_freq;
    logic signed [15:0] line_freq;
    logic signed [15:0] motor_phase;
    logic signed [15:0] line_phase;
  } sync_inputs_t;
endpackage

// *** sync_compare.sv ***
// Line synchroniser: picks voltage source, forms differences and compares with thresholds.
`include "bypass_defs.svh"
module sync_compare (
  // Clock and reset.
  input  wire logic                  i_mclk,
  input  wire logic                  i_srst,
  // Configuration.
  input  wire logic                  i_enable,
  input  wire logic [1:0]            i_source,
  input  wire logic signed [15:0]    i_phase_offset,
  input  wire logic [15:0]           i_freq_thr,
  input  wire logic [15:0]           i_phase_thr,
  input  wire logic [15:0]           i_volt_thr,
  // Measured quantities.
  input  wire bypass_pkg::sync_inputs_t i_meas,
  // Results.
  output logic signed [15:0]         o_target_freq,
  output logic signed [15:0]         o_freq_diff,
  output logic signed [15:0]         o_phase_diff,
  output logic signed [15:0]         o_volt_diff,
  output logic [2:0]                 o_status
);
  logic signed [15:0] mot_u12;
  logic signed [15:0] mot_u23;
  logic signed [15:0] next_fd;
  logic signed [15:0] next_pd;
  logic signed [15:0] next_vd;
  logic [2:0]         next_status;

  // Voltage source follows the activation setting; other settings use zero motor voltages and force the status to zero.
  always_comb
  begin
    mot_u12 = 16'sh0000;
    mot_u23 = 16'sh0000;
    if (i_source == `SYNC_INTERNAL)
    begin
      mot_u12 = i_meas.model_u12; // R12
      mot_u23 = i_meas.model_u23;
    end
    else if (i_source == `SYNC_EXTERNAL)
    begin
      mot_u12 = i_meas.u12; // R13
      mot_u23 = i_meas.u23;
    end
    next_fd = 16'(i_meas.line_freq - i_meas.motor_freq);
    next_pd = 16'(i_meas.line_phase - i_meas.motor_phase - i_phase_offset); // R14
    next_vd = 16'((i_meas.line_u12 - mot_u12) + (i_meas.line_u23 - mot_u23));
    next_status[0] = ((next_fd < 0) ? 16'(-next_fd) : 16'(next_fd)) <= i_freq_thr; // R15
    next_status[1] = ((next_vd < 0) ? 16'(-next_vd) : 16'(next_vd)) <= i_volt_thr;
    next_status[`BIT_SYNC_MATCH] = next_status[0] && next_status[1] &&
      (((next_pd < 0) ? 16'(-next_pd) : 16'(next_pd)) <= i_phase_thr);
    if (!i_enable || (i_source != `SYNC_INTERNAL && i_source != `SYNC_EXTERNAL))
    begin
      next_status = 3'h0;
    end
  end

  // Results are registered so the sequencer sees a settled match flag.
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      o_target_freq <= 16'sh0000;
      o_freq_diff   <= 16'sh0000;
      o_phase_diff  <= 16'sh0000;
      o_volt_diff   <= 16'sh0000;
      o_status      <= 3'h0;
    end
    else
    begin
      o_target_freq <= i_meas.line_freq; // R15
      o_freq_diff   <= next_fd;
      o_phase_diff  <= next_pd;
      o_volt_diff   <= next_vd;
      o_status      <= next_status;
    end
  end
endmodule

// *** bypass_sequencer.sv ***
// Bypass sequencer: contactor changeover between converter and line feed, with APB registers.
// Overview of operation
// R01: On fault trigger, inhibit pulses, run bypass delay, then start changeover; in overlap mode (1) the code goes straight to sync wait.
// R02: First changeover step opens converter contactor, control bit 0 low.
// R03: Software sets deadtime no shorter than motor de-excitation time.
// R04: After deadtime, close line contactor, control bit 1 high.
// R05: After trigger clears, wait return delay before handing back.
// R06: Return starts by opening line contactor, control bit 1 low.
// R07: After another deadtime close converter contactor, bit 0 high, resume.
// R08: Three trigger source bits; control input honoured only with bit 0 set.
// R09: Speed threshold compared only when trigger source bit 1 set.
// R10: Feedback index 0 is converter contactor, index 1 line contactor.
// R11: Synchroniser enable is driven from control bit 2.
// R12: Activation 1 uses internal motor model voltages.
// R13: Activation 2 uses external U12 and U23 inputs.
// R14: Synchroniser applies a configurable phase offset.
// R15: Report target frequency and differences, compare against thresholds.
// R16: Sync match (status bit 2) closes the line contactor directly; code does so in mode 1 only, mode 2 opens converter contactor first.
// R17: Overlap: open converter contactor and inhibit pulses after line feedback.
// R18: Without synchronisation contactors never commanded closed together.
// R19: Timers count clock cycles and restart when their step is entered.
`include "bypass_defs.svh"
module bypass_sequencer (
  // Clock and reset.
  input  wire logic                     i_mclk,
  input  wire logic                     i_srst,
  // APB slave.
  input  wire logic                     i_psel,
  input  wire logic                     i_penable,
  input  wire logic                     i_pwrite,
  input  wire logic [11:0]              i_paddr,
  input  wire logic [31:0]              i_pwdata,
  output logic [31:0]                   o_prdata,
  output logic                          o_pready,
  output logic                          o_pslverr,
  // Triggers, feedback and measurements.
  input  wire bypass_pkg::triggers_t    i_trig,
  input  wire logic [1:0]               i_contactor_feedback,
  input  wire bypass_pkg::sync_inputs_t i_meas,
  // Contactor and drive commands.
  output logic                          o_converter_contactor,
  output logic                          o_line_contactor,
  output logic                          o_pulse_inhibit,
  output logic                          o_sync_enable
);
  logic [1:0]  bypass_configuration;
  logic [31:0] transfer_deadtime;
  logic [31:0] return_delay_time;
  logic [31:0] fault_transfer_delay;
  logic [15:0] speed_threshold_level;
  logic [2:0]  trigger_source_select;
  logic [1:0]  sync_activation_select;
  logic signed [15:0] sync_phase_offset;
  logic [15:0] freq_thr;
  logic [15:0] phase_thr;
  logic [15:0] volt_thr;
  logic [31:0] next_reg_a;
  logic        wr_en;
  logic        rd_en;
  bypass_pkg::seq_state_t state;
  bypass_pkg::seq_state_t next_state;
  logic [31:0] timer;
  logic [31:0] next_timer;
  logic [4:0]  bypass_ctrl_status_word;
  logic [4:0]  next_ctrl;
  logic        want_bypass;
  logic        fault_trig;
  logic        sync_mode;
  logic signed [15:0] target_freq;
  logic signed [15:0] freq_diff;
  logic signed [15:0] phase_diff;
  logic signed [15:0] volt_diff;
  logic [2:0]  sync_status_word;

  // Zero wait states: the access phase completes in its first cycle.
  assign o_pready  = 1'b1;
  assign o_pslverr = 1'b0;
  assign wr_en     = i_psel && i_penable && i_pwrite;
  assign rd_en     = i_psel && !i_penable && !i_pwrite;
  assign next_reg_a = i_pwdata;

  // Configuration registers; a write lands on the access edge only.
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      bypass_configuration   <= 2'h0;
      transfer_deadtime      <= `RST_DEADTIME;
      return_delay_time      <= `RST_RETURN;
      fault_transfer_delay   <= `RST_FAULTDLY;
      speed_threshold_level  <= 16'h0000;
      trigger_source_select  <= 3'h0;
      sync_activation_select <= 2'h0;
      sync_phase_offset      <= 16'sh0000;
      freq_thr               <= 16'h0000;
      phase_thr              <= 16'h0000;
      volt_thr               <= 16'h0000;
    end
    else if (wr_en)
    begin
      unique case (i_paddr)
        `ADDR_CONFIG:    bypass_configuration  <= next_reg_a[1:0];
        `ADDR_DEADTIME:  transfer_deadtime     <= next_reg_a; // R03
        `ADDR_RETURN:    return_delay_time     <= next_reg_a;
        `ADDR_FAULTDLY:  fault_transfer_delay  <= next_reg_a;
        `ADDR_SPEED_THR: speed_threshold_level <= next_reg_a[15:0];
        `ADDR_TRIG_SRC:  trigger_source_select <= next_reg_a[2:0];
        `ADDR_SYNC_CFG:
        begin
          sync_activation_select <= next_reg_a[17:16];
          sync_phase_offset      <= next_reg_a[15:0];
        end
        `ADDR_SYNC_THR:
        begin
          freq_thr  <= {6'h00, next_reg_a[9:0]};
          phase_thr <= {6'h00, next_reg_a[19:10]};
          volt_thr  <= {6'h00, next_reg_a[29:20]};
        end
        default: ;
      endcase
    end
  end

  // Read data is captured in the setup cycle so it stands through the access phase.
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      o_prdata <= 32'h0000_0000;
    end
    else if (rd_en)
    begin
      unique case (i_paddr)
        `ADDR_CONFIG:      o_prdata <= {30'h0, bypass_configuration};
        `ADDR_DEADTIME:    o_prdata <= transfer_deadtime;
        `ADDR_RETURN:      o_prdata <= return_delay_time;
        `ADDR_FAULTDLY:    o_prdata <= fault_transfer_delay;
        `ADDR_SPEED_THR:   o_prdata <= {16'h0, speed_threshold_level};
        `ADDR_TRIG_SRC:    o_prdata <= {29'h0, trigger_source_select};
        `ADDR_SYNC_CFG:    o_prdata <= {14'h0, sync_activation_select, sync_phase_offset};
        `ADDR_SYNC_THR:    o_prdata <= {2'h0, volt_thr[9:0], phase_thr[9:0], freq_thr[9:0]};
        `ADDR_CTRL_STATUS: o_prdata <= {21'h0, i_contactor_feedback, 4'(state),
                                        bypass_ctrl_status_word};
        `ADDR_SYNC_DIFF:   o_prdata <= {freq_diff, phase_diff};
        `ADDR_SYNC_STATUS: o_prdata <= {volt_diff, target_freq[12:0], sync_status_word};
        default:           o_prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Trigger evaluation, each source gated by its own select bit.
  always_comb
  begin
    fault_trig  = trigger_source_select[`TRIG_FAULT] && i_trig.fault;
    want_bypass = (trigger_source_select[`TRIG_CTRL] && i_trig.ctrl_request) || // R08
                  (trigger_source_select[`TRIG_SPEED] &&
                   (i_trig.speed_setpoint > speed_threshold_level)) || // R09
                  fault_trig;
    sync_mode   = (bypass_configuration == `MODE_SYNC_OVL) ||
                  (bypass_configuration == `MODE_SYNC_NOOVL);
  end

  // Sequence state, timer and command word; the timer reloads on entry to each timed step.
  always_comb
  begin
    next_state = state;
    next_timer = (timer != 32'h0) ? 32'(timer - 32'h1) : 32'h0; // R19
    next_ctrl  = bypass_ctrl_status_word;
    unique case (state)
      bypass_pkg::ST_CONV:
      begin
        if (want_bypass && bypass_configuration != 2'h0)
        begin
          if (bypass_configuration == `MODE_SYNC_OVL)
          begin
            next_ctrl[`BIT_SYNC_REQ] = 1'b1;
            next_state = bypass_pkg::ST_SYNC_WAIT;
          end
          else if (fault_trig)
          begin
            next_ctrl[`BIT_PULSE_INH] = 1'b1; // R01
            next_timer = fault_transfer_delay;
            next_state = bypass_pkg::ST_FAULT_DLY;
          end
          else
          begin
            next_ctrl[`BIT_SYNC_REQ] = (bypass_configuration == `MODE_SYNC_NOOVL);
            next_state = (bypass_configuration == `MODE_SYNC_NOOVL) ?
                         bypass_pkg::ST_SYNC_WAIT : bypass_pkg::ST_OPEN_CONV;
          end
        end
      end
      bypass_pkg::ST_FAULT_DLY:
      begin
        if (timer == 32'h0)
        begin
          next_state = bypass_pkg::ST_OPEN_CONV; // R01
        end
      end
      bypass_pkg::ST_SYNC_WAIT:
      begin
        if (sync_status_word[`BIT_SYNC_MATCH])
        begin
          if (bypass_configuration == `MODE_SYNC_OVL)
          begin
            next_ctrl[`BIT_LINE_CONT] = 1'b1; // R16
            next_state = bypass_pkg::ST_LINE_WAIT;
          end
          else
          begin
            next_state = bypass_pkg::ST_OPEN_CONV;
          end
        end
      end
      bypass_pkg::ST_OPEN_CONV:
      begin
        next_ctrl[`BIT_CONV_CONT] = 1'b0; // R02
        next_ctrl[`BIT_PULSE_INH] = 1'b1;
        next_timer = transfer_deadtime; // R19
        next_state = bypass_pkg::ST_DEAD_IN;
      end
      bypass_pkg::ST_DEAD_IN:
      begin
        if (timer == 32'h0 && !i_contactor_feedback[0]) // R18
        begin
          next_ctrl[`BIT_LINE_CONT] = 1'b1; // R04
          next_ctrl[`BIT_SYNC_REQ]  = 1'b0;
          next_ctrl[`BIT_BYPASSED]  = 1'b1;
          next_state = bypass_pkg::ST_BYPASSED;
        end
      end
      bypass_pkg::ST_LINE_WAIT:
      begin
        if (i_contactor_feedback[1]) // R10
        begin
          next_ctrl[`BIT_CONV_CONT] = 1'b0; // R17
          next_ctrl[`BIT_PULSE_INH] = 1'b1;
          next_ctrl[`BIT_SYNC_REQ]  = 1'b0;
          next_ctrl[`BIT_BYPASSED]  = 1'b1;
          next_state = bypass_pkg::ST_BYPASSED;
        end
      end
      bypass_pkg::ST_BYPASSED:
      begin
        if (!want_bypass)
        begin
          next_timer = return_delay_time;
          next_state = bypass_pkg::ST_RET_DLY;
        end
      end
      bypass_pkg::ST_RET_DLY:
      begin
        if (want_bypass)
        begin
          next_state = bypass_pkg::ST_BYPASSED;
        end
        else if (timer == 32'h0) // R05
        begin
          if (bypass_configuration == `MODE_SYNC_OVL)
          begin
            next_ctrl[`BIT_SYNC_REQ]  = 1'b1;
            next_ctrl[`BIT_PULSE_INH] = 1'b0;
            next_state = bypass_pkg::ST_CONV_WAIT;
          end
          else
          begin
            next_state = bypass_pkg::ST_OPEN_LINE;
          end
        end
      end
      bypass_pkg::ST_CONV_WAIT:
      begin
        if (sync_status_word[`BIT_SYNC_MATCH] && !bypass_ctrl_status_word[`BIT_CONV_CONT])
        begin
          next_ctrl[`BIT_CONV_CONT] = 1'b1;
        end
        else if (i_contactor_feedback[0]) // R10
        begin
          next_ctrl = 5'h01;
          next_state = bypass_pkg::ST_CONV;
        end
      end
      bypass_pkg::ST_OPEN_LINE:
      begin
        next_ctrl[`BIT_LINE_CONT] = 1'b0; // R06
        next_timer = transfer_deadtime; // R19
        next_state = bypass_pkg::ST_DEAD_OUT;
      end
      bypass_pkg::ST_DEAD_OUT:
      begin
        if (timer == 32'h0 && !i_contactor_feedback[1]) // R18
        begin
          next_ctrl = 5'h01; // R07
          next_state = bypass_pkg::ST_CONV;
        end
      end
      default:
      begin
        next_ctrl  = 5'h08;
        next_state = bypass_pkg::ST_CONV;
      end
    endcase
  end

  // Sequence registers.
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      state                   <= bypass_pkg::ST_CONV;
      timer                   <= 32'h0;
      bypass_ctrl_status_word <= 5'h01;
    end
    else
    begin
      state                   <= next_state;
      timer                   <= next_timer;
      bypass_ctrl_status_word <= next_ctrl;
    end
  end

  // Command outputs come straight from the control word flip-flops.
  assign o_converter_contactor = bypass_ctrl_status_word[`BIT_CONV_CONT];
  assign o_line_contactor      = bypass_ctrl_status_word[`BIT_LINE_CONT];
  assign o_pulse_inhibit       = bypass_ctrl_status_word[`BIT_PULSE_INH];
  assign o_sync_enable         = bypass_ctrl_status_word[`BIT_SYNC_REQ]; // R11

  sync_compare u_sync (
    .i_mclk         (i_mclk),
    .i_srst         (i_srst),
    .i_enable       (o_sync_enable), // R11
    .i_source       (sync_activation_select),
    .i_phase_offset (sync_phase_offset),
    .i_freq_thr     (freq_thr),
    .i_phase_thr    (phase_thr),
    .i_volt_thr     (volt_thr),
    .i_meas         (i_meas),
    .o_target_freq  (target_freq),
    .o_freq_diff    (freq_diff),
    .o_phase_diff   (phase_diff),
    .o_volt_diff    (volt_diff),
    .o_status       (sync_status_word)
  );

  a_no_overlap_cmd: assert property (@(posedge i_mclk) disable iff (i_srst) // R18
    (bypass_configuration == `MODE_NOSYNC) |-> !(o_converter_contactor && o_line_contactor))
    else $error("both contactors commanded in non-synchronised bypass");
  a_fault_inhibit_first: assert property (@(posedge i_mclk) disable iff (i_srst) // R01
    (state == bypass_pkg::ST_FAULT_DLY) |-> o_pulse_inhibit && o_converter_contactor)
    else $error("fault delay without pulse inhibit");
  a_open_conv_step: assert property (@(posedge i_mclk) disable iff (i_srst) // R02
    (state == bypass_pkg::ST_OPEN_CONV) |=> !o_converter_contactor)
    else $error("converter contactor not opened");
  a_line_close_dead: assert property (@(posedge i_mclk) disable iff (i_srst) // R04
    $rose(o_line_contactor) && bypass_configuration == `MODE_NOSYNC
    |-> $past(state) == bypass_pkg::ST_DEAD_IN && $past(timer) == 32'h0)
    else $error("line contactor closed before deadtime");
  a_return_delay: assert property (@(posedge i_mclk) disable iff (i_srst) // R05
    (state == bypass_pkg::ST_RET_DLY && timer != 32'h0 && !want_bypass)
    |=> state == bypass_pkg::ST_RET_DLY)
    else $error("return started before delay expired");
  a_open_line_step: assert property (@(posedge i_mclk) disable iff (i_srst) // R06
    (state == bypass_pkg::ST_OPEN_LINE) |=> !o_line_contactor ##1 !o_converter_contactor)
    else $error("return did not open line contactor first");
  a_conv_close_dead: assert property (@(posedge i_mclk) disable iff (i_srst) // R07
    $rose(o_converter_contactor) && $past(state) == bypass_pkg::ST_DEAD_OUT
    |-> $past(timer) == 32'h0 && !o_line_contactor)
    else $error("converter contactor closed early");
  a_ctrl_gate: assert property (@(posedge i_mclk) disable iff (i_srst) // R08
    (state == bypass_pkg::ST_CONV && trigger_source_select == 3'h0) |=> state == bypass_pkg::ST_CONV)
    else $error("bypass started with no trigger source");
  a_overlap_fb: assert property (@(posedge i_mclk) disable iff (i_srst) // R17
    (state == bypass_pkg::ST_LINE_WAIT && i_contactor_feedback[1])
    |=> !o_converter_contactor && o_pulse_inhibit && state == bypass_pkg::ST_BYPASSED)
    else $error("overlap transfer did not release converter contactor");
  a_sync_close: assert property (@(posedge i_mclk) disable iff (i_srst) // R16
    (state == bypass_pkg::ST_SYNC_WAIT && sync_status_word[2] &&
     bypass_configuration == `MODE_SYNC_OVL) |=> o_line_contactor)
    else $error("sync match did not close line contactor");
endmodule

// *** contactor_model.sv ***
// Behavioural pair of contactors that report closed some cycles after their close command.
module contactor_model #(
  parameter int LAG = 3
) (
  // Clock.
  input  wire logic       i_mclk,
  // Close commands.
  input  wire logic       i_conv_cmd,
  input  wire logic       i_line_cmd,
  // Closed feedback, index 0 converter side, index 1 line side.
  output logic [1:0]      o_feedback
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] pipe [LAG];
  // Mechanical travel takes time, so feedback trails the command by LAG cycles.
  always_ff @(posedge i_mclk)
  begin
    pipe[0] <= {i_line_cmd, i_conv_cmd};
    for (int i = 1; i < LAG; i++)
      pipe[i] <= pipe[i - 1];
  end
  assign o_feedback = pipe[LAG - 1];
endmodule

// *** motor_bypass_sequencer_tb.sv ***
// Self-checking testbench for the bypass sequencer.
`include "bypass_defs.svh"
module motor_bypass_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // Deadtime outlasts the contactor model's travel, standing in for de-excitation time.
  localparam int DEAD = 5;
  localparam int RET = 6;
  localparam int FDLY = 4;
  typedef struct packed {
    logic        wr;
    logic [11:0] addr;
    logic [31:0] data;
    logic [31:0] exp;
  } row_t;
  logic                     clk = 1'b0;
  logic                     srst = 1'b1;
  logic                     psel = 1'b0;
  logic                     penable = 1'b0;
  logic                     pwrite = 1'b0;
  logic [11:0]              paddr = 12'h000;
  logic [31:0]              pwdata = 32'h0;
  logic [31:0]              prdata;
  logic                     pready;
  logic                     pslverr;
  logic [31:0]              q;
  bypass_pkg::triggers_t    trig = '0;
  bypass_pkg::sync_inputs_t meas = '0;
  logic [1:0]               fb;
  logic                     conv;
  logic                     line;
  logic                     inh;
  logic                     sen;
  int                       c;
  int                       err_count = 0;
  int                       n_checks = 0;
  // Reset values first, then write, unmapped and read-only accesses.
  row_t rows [10] = '{
    '{1'b0, `ADDR_DEADTIME, 32'h0, `RST_DEADTIME},
    '{1'b0, `ADDR_RETURN, 32'h0, `RST_RETURN},
    '{1'b0, `ADDR_FAULTDLY, 32'h0, `RST_FAULTDLY},
    '{1'b0, `ADDR_CTRL_STATUS, 32'h0, 32'h0000_0201},
    '{1'b1, `ADDR_DEADTIME, DEAD, 32'h0},
    '{1'b0, `ADDR_DEADTIME, 32'h0, DEAD},
    '{1'b1, 12'h0FC, 32'hFFFF_FFFF, 32'h0},
    '{1'b0, 12'h0FC, 32'h0, 32'h0},
    '{1'b1, `ADDR_CTRL_STATUS, 32'h0000_001F, 32'h0},
    '{1'b0, `ADDR_CTRL_STATUS, 32'h0, 32'h0000_0201}
  };
  // Free-running 50 MHz clock.
  always #10 clk = ~clk;
  bypass_sequencer dut_u (.i_mclk(clk), .i_srst(srst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_trig(trig), .i_contactor_feedback(fb),
    .i_meas(meas),
    .o_converter_contactor(conv), .o_line_contactor(line), .o_pulse_inhibit(inh),
    .o_sync_enable(sen));
  contactor_model #(.LAG(3)) model_u (.i_mclk(clk), .i_conv_cmd(conv), .i_line_cmd(line),
    .o_feedback(fb));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // One APB transfer; the request is held until pready is seen, only the watchdog ends a wait.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    q = prdata;
    check(32'(pslverr), 32'h0);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Waits on a settled output: 0 converter, 1 line, 2 inhibit, 3 sync enable.
  task automatic wait_out(input int s, input logic v);
    c = 0;
    while ((s == 0 ? conv : s == 1 ? line : s == 2 ? inh : sen) !== v && c < 300)
    begin
      @(negedge clk);
      c++;
    end
    check(32'(c < 300), 32'h1);
  endtask
  // Speed trigger sits above or below the threshold of 0x100.
  task automatic arm(input logic [2:0] m);
    @(posedge clk);
    trig.ctrl_request <= m[0];
    trig.speed_setpoint <= m[1] ? 16'h0200 : 16'h0080;
    trig.fault <= m[2];
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    check({28'h0, conv, line, inh, sen}, 32'h8);
    for (int i = 0; i < 10; i++)
    begin
      apb(rows[i].wr, rows[i].addr, rows[i].data);
      if (!rows[i].wr)
        check(q, rows[i].exp);
    end
    $display("test registers done");
    apb(1'b1, `ADDR_RETURN, RET);
    apb(1'b1, `ADDR_FAULTDLY, FDLY);
    apb(1'b1, `ADDR_SPEED_THR, 32'h0000_0100);
    apb(1'b1, `ADDR_CONFIG, 32'h3);
    // Each trigger source in turn, with the other two asserted first and ignored.
    for (int k = 0; k < 3; k++)
    begin
      apb(1'b1, `ADDR_TRIG_SRC, 32'(1 << k));
      arm(3'b111 & ~(3'b001 << k));
      repeat (30) @(posedge clk);
      check(32'(conv), 32'h1);
      arm(3'b001 << k);
      wait_out(2, 1'b1);
      if (k == 2)
        check(32'(conv), 32'h1);
      wait_out(0, 1'b0);
      if (k == 2)
        check(32'(c >= FDLY), 32'h1);
      wait_out(1, 1'b1);
      check(32'(c >= DEAD), 32'h1);
      check(32'(conv), 32'h0);
      arm(3'b000);
      wait_out(1, 1'b0);
      check(32'(c >= RET), 32'h1);
      wait_out(0, 1'b1);
      check(32'(c >= DEAD), 32'h1);
      check(32'(inh), 32'h0);
      $display("test trigger %0d done", k);
    end
    // Overlapping synchronised transfer; frequency mismatch first, then match.
    apb(1'b1, `ADDR_SYNC_THR, 32'h00A0_280A);
    apb(1'b1, `ADDR_SYNC_CFG, 32'h0001_0000);
    apb(1'b1, `ADDR_TRIG_SRC, 32'h1);
    apb(1'b1, `ADDR_CONFIG, 32'h1);
    meas.motor_freq <= 16'sd100;
    meas.line_freq <= 16'sd200;
    arm(3'b001);
    wait_out(3, 1'b1);
    repeat (20) @(posedge clk);
    check(32'(line), 32'h0);
    meas.motor_freq <= 16'sd200;
    wait_out(1, 1'b1);
    check(32'(conv), 32'h1);
    apb(1'b0, `ADDR_SYNC_STATUS, 32'h0);
    check(32'(q[2]), 32'h1);
    check(32'(conv), 32'h1);
    wait_out(0, 1'b0);
    check(32'(fb[1]), 32'h1);
    check(32'(inh), 32'h1);
    arm(3'b000);
    wait_out(0, 1'b1);
    wait_out(1, 1'b0);
    check(32'(inh), 32'h0);
    $display("test overlap done");
    // External voltage source and phase offset show up in the difference words.
    apb(1'b1, `ADDR_SYNC_CFG, 32'h0002_0007);
    meas.u12 <= 16'sh0005;
    apb(1'b0, `ADDR_SYNC_STATUS, 32'h0);
    check(32'(q[31:16]), 32'h0000_FFFB);
    check(32'(q[15:3]), 32'h0000_00C8);
    check(32'(q[2:0]), 32'h0);
    apb(1'b0, `ADDR_SYNC_DIFF, 32'h0);
    check(q, 32'h0000_FFF9);
    // Reset in mid-transfer returns the contactors and registers to idle.
    arm(3'b001);
    wait_out(1, 1'b1);
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    check({28'h0, conv, line, inh, sen}, 32'h8);
    arm(3'b000);
    apb(1'b0, `ADDR_DEADTIME, 32'h0);
    check(q, `RST_DEADTIME);
    $display("test sync and reset done");
    complete_run();
  end
  // Watchdog: the whole sequence needs a few thousand cycles at most.
  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    complete_run();
  end
endmodule
